//--- rtl/usb_susp_pkg.sv
package usb_susp_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 100;   // system clock rate
    localparam int SUSP_IDLE_MS = 5;     // uninterrupted j state before suspend
    localparam int K_EXT_US     = 1500;  // k hold after pulse end, inside 1..2 ms
    localparam int K_MAX_MS     = 15;    // longest allowed resume signalling
    localparam int SUSP_IDLE_CYC = SUSP_IDLE_MS * 1000 * CLK_MHZ;
    localparam int K_EXT_CYC     = K_EXT_US * CLK_MHZ;
    localparam int K_MAX_CYC     = K_MAX_MS * 1000 * CLK_MHZ;
    localparam int CNT_W         = 21;   // wide enough for the 15 ms count

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_USB_CTRL  = 8'h00; // usb_control_register
    localparam logic [7:0] OFS_GLOB_CTRL = 8'h04; // global_control_register
    localparam logic [7:0] OFS_PWR_CTRL  = 8'h08; // mcu_power_control
    localparam logic [7:0] OFS_VECTOR    = 8'h0c; // interrupt_vector_register
    localparam logic [7:0] OFS_WAKE_MASK = 8'h10; // port three wake mask
    localparam logic [7:0] OFS_STATUS    = 8'h14; // flags and state

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_RWAKE_PULSE = 0; // usb_control: remote_wake_pulse_bit
    localparam int BIT_RWAKE_EN    = 1; // usb_control: host granted remote wake
    localparam int BIT_EXTERNAL_INTERRUPT_PIN_EN     = 0; // global_control: ext_interrupt_enable
    localparam int BIT_IDLE        = 0; // mcu_power_control: idle_mode_bit
    localparam int BIT_EXT_PIN     = 2; // port three bit shared with ext pin
    localparam int ST_SUSP_REQ     = 0;
    localparam int ST_RES_REQ      = 1;
    localparam int ST_WAKE         = 2;
    localparam int ST_SUSPENDED    = 3;
    localparam int ST_K_DRIVE      = 4;
    localparam int ST_CLK_RUN      = 5;

    // ------------------------------------------------------------
    // vectors and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_NONE    = 8'h00;
    localparam logic [7:0] VEC_SUSPEND = 8'h16;
    localparam logic [7:0] VEC_RESUME  = 8'h18;
    localparam logic [7:0] VEC_EXTERNAL_INTERRUPT_PIN    = 8'h1f;
    localparam logic [7:0] WAKE_MASK_RST = 8'hff;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // k state sequencer
    typedef enum logic [1:0] {K_OFF, K_PULSE, K_EXT} k_state_t;
endpackage

//--- rtl/usb_suspend_resume_wakeup.sv
`timescale 1ns/1ps
module usb_suspend_resume_wakeup #(
    parameter int SUSP_IDLE_CYC = usb_susp_pkg::SUSP_IDLE_CYC,
    parameter int K_EXT_CYC     = usb_susp_pkg::K_EXT_CYC,
    parameter int K_MAX_CYC     = usb_susp_pkg::K_MAX_CYC,
    parameter int PORT_W        = 8
) (
    // clock, reset, enable
    input  wire logic              i_sys_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    // axi4-lite write address / data / response
    input  wire logic              i_awvalid,
    input  wire logic [7:0]        i_awaddr,
    output logic                   o_awready,
    input  wire logic              i_wvalid,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    output logic                   o_wready,
    output logic                   o_bvalid,
    output logic [1:0]             o_bresp,
    input  wire logic              i_bready,
    // axi4-lite read address / data
    input  wire logic              i_arvalid,
    input  wire logic [7:0]        i_araddr,
    output logic                   o_arready,
    output logic                   o_rvalid,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    input  wire logic              i_rready,
    // usb line state
    input  wire logic              i_bus_idle,
    input  wire logic              i_bus_active,
    // port three and external pin (active low)
    input  wire logic [PORT_W-1:0] i_port_three,
    input  wire logic              i_ext_int_pin_n,
    // mcu status
    input  wire logic              i_mcu_in_isr,
    // outputs to mcu and clocks
    output logic                   o_clk_run,
    output logic                   o_k_drive,
    output logic                   o_int_zero,
    output logic                   o_usb_irq,
    output logic                   o_suspended
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          aw_ok;    // address held
        logic [7:0]                    awaddr;
        logic                          w_ok;     // data held
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic                          awready;
        logic                          wready;
        logic                          arready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic                          rwake_pulse; // remote_wake_pulse_bit
        logic                          rwake_en;    // feature granted
        logic                          external_interrupt_pin_en;     // ext_interrupt_enable
        logic                          idle_mode;   // idle_mode_bit
        logic [PORT_W-1:0]             wake_mask;
        logic                          susp_req;    // suspend_request_flag
        logic                          res_req;     // resume_request_flag
        logic                          wake;        // wake flip-flop
        logic                          ext_flag;    // normal pin interrupt
        logic                          gate_prev;   // last gated wake level
        logic                          pin_prev;
        logic [usb_susp_pkg::CNT_W-1:0] idle_cnt;
        logic                          susp_cond;   // 5 ms idle seen
        usb_susp_pkg::k_state_t        k_st;
        logic [usb_susp_pkg::CNT_W-1:0] k_cnt;      // hold after pulse
        logic [usb_susp_pkg::CNT_W-1:0] k_total;    // whole signalling
        logic                          k_drive;
        logic                          clk_run;
        logic                          int_zero;
        logic                          usb_irq;
        logic                          suspended;
    } state_t;

    state_t s_q;  // registered state
    state_t s_d;  // next state

    localparam logic [usb_susp_pkg::CNT_W-1:0] IDLE_LIM =
        usb_susp_pkg::CNT_W'(SUSP_IDLE_CYC - 1);
    localparam logic [usb_susp_pkg::CNT_W-1:0] KEXT_LIM =
        usb_susp_pkg::CNT_W'(K_EXT_CYC - 1);
    localparam logic [usb_susp_pkg::CNT_W-1:0] KMAX_LIM =
        usb_susp_pkg::CNT_W'(K_MAX_CYC - 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // current vector, suspend above resume above pin
    function automatic logic [7:0] cur_vec(input state_t s);
        if (s.susp_req) begin
            cur_vec = usb_susp_pkg::VEC_SUSPEND;
        end else if (s.res_req) begin
            cur_vec = usb_susp_pkg::VEC_RESUME;
        end else if ((s.wake || s.ext_flag) && s.external_interrupt_pin_en) begin
            cur_vec = usb_susp_pkg::VEC_EXTERNAL_INTERRUPT_PIN;
        end else begin
            cur_vec = usb_susp_pkg::VEC_NONE;
        end
    endfunction

    // known register offset
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == usb_susp_pkg::OFS_USB_CTRL)  ||
                  (a == usb_susp_pkg::OFS_GLOB_CTRL) ||
                  (a == usb_susp_pkg::OFS_PWR_CTRL)  ||
                  (a == usb_susp_pkg::OFS_VECTOR)    ||
                  (a == usb_susp_pkg::OFS_WAKE_MASK) ||
                  (a == usb_susp_pkg::OFS_STATUS);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic              do_wr;
        logic              do_rd;
        logic [7:0]        vec;
        logic [PORT_W-1:0] pins;
        logic              gate;
        logic              clr_susp;
        logic              clr_res;
        logic              clr_wake;
        logic              pulse_fall;
        s_d        = s_q;
        do_wr      = 1'b0;
        do_rd      = 1'b0;
        vec        = cur_vec(s_q);
        pins       = i_port_three;
        gate       = 1'b0;
        clr_susp   = 1'b0;
        clr_res    = 1'b0;
        clr_wake   = 1'b0;
        pulse_fall = 1'b0;

        // bus: latch address and data in either order
        if (i_awvalid && s_q.awready) begin
            s_d.aw_ok  = 1'b1;
            s_d.awaddr = i_awaddr;
        end
        if (i_wvalid && s_q.wready) begin
            s_d.w_ok  = 1'b1;
            s_d.wdata = i_wdata;
            s_d.wstrb = i_wstrb;
        end
        if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end
        // both halves held and no response pending: commit
        if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
            do_wr      = 1'b1;
            s_d.aw_ok  = 1'b0;
            s_d.w_ok   = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = addr_ok(s_q.awaddr) ? usb_susp_pkg::RESP_OKAY
                                             : usb_susp_pkg::RESP_SLVERR;
        end

        // register writes, only low byte lane carries fields
        if (do_wr && s_q.wstrb[0]) begin
            unique case (s_q.awaddr)
                usb_susp_pkg::OFS_USB_CTRL: begin
                    // pulse only counts once the host granted it
                    s_d.rwake_en    = s_q.wdata[usb_susp_pkg::BIT_RWAKE_EN];
                    s_d.rwake_pulse = s_q.wdata[usb_susp_pkg::BIT_RWAKE_PULSE]
                                      && s_d.rwake_en;
                end
                usb_susp_pkg::OFS_GLOB_CTRL: begin
                    s_d.external_interrupt_pin_en = s_q.wdata[usb_susp_pkg::BIT_EXTERNAL_INTERRUPT_PIN_EN];
                end
                usb_susp_pkg::OFS_PWR_CTRL: begin
                    // setting idle from a handler would strand interrupt zero
                    if (!i_mcu_in_isr || !s_q.wdata[usb_susp_pkg::BIT_IDLE]) begin
                        s_d.idle_mode = s_q.wdata[usb_susp_pkg::BIT_IDLE];
                    end
                end
                usb_susp_pkg::OFS_VECTOR: begin
                    // data is ignored; the write itself acknowledges
                    clr_susp = (vec == usb_susp_pkg::VEC_SUSPEND);
                    clr_res  = (vec == usb_susp_pkg::VEC_RESUME);
                    clr_wake = (vec == usb_susp_pkg::VEC_EXTERNAL_INTERRUPT_PIN);
                end
                usb_susp_pkg::OFS_WAKE_MASK: begin
                    s_d.wake_mask = s_q.wdata[PORT_W-1:0];
                end
                default: begin
                    // unmapped: answered with slverr, nothing stored
                end
            endcase
        end

        // ------------------------------------------------------------
        // suspend detection
        // ------------------------------------------------------------
        // any break in the j state restarts the 5 ms count
        if (!i_bus_idle) begin
            s_d.idle_cnt  = '0;
            s_d.susp_cond = 1'b0;
        end else if (s_q.idle_cnt == IDLE_LIM) begin
            s_d.susp_cond = 1'b1;
        end else begin
            s_d.idle_cnt = s_q.idle_cnt + 1'b1;
        end
        // flag sticks; a new condition wins over its clear
        if (clr_susp) begin
            s_d.susp_req = 1'b0;
        end
        if (s_d.susp_cond && !s_q.susp_cond) begin
            s_d.susp_req = 1'b1;
        end

        // suspended: idle bit set, condition held, no wake pending
        s_d.suspended = s_d.idle_mode && s_q.susp_cond &&
                        !s_q.wake && !s_q.res_req;

        // ------------------------------------------------------------
        // bus resume
        // ------------------------------------------------------------
        if (clr_res) begin
            s_d.res_req = 1'b0;
        end
        if (s_q.suspended && i_bus_active) begin
            s_d.res_req   = 1'b1;
            s_d.idle_mode = 1'b0;
            s_d.suspended = 1'b0;
        end

        // ------------------------------------------------------------
        // local wake
        // ------------------------------------------------------------
        // in suspend the external pin stands in for bit two
        if (s_q.suspended) begin
            pins[usb_susp_pkg::BIT_EXT_PIN] = i_ext_int_pin_n;
        end
        // low input with clear mask counts; a set mask hides it
        gate = (|(~pins & ~s_q.wake_mask)) && s_q.suspended;
        s_d.gate_prev = gate;
        if (clr_wake) begin
            s_d.wake     = 1'b0;
            s_d.ext_flag = 1'b0;
        end
        if (gate && !s_q.gate_prev) begin
            s_d.wake      = 1'b1;
            s_d.suspended = 1'b0;
        end
        // normal pin interrupt only while clocks run
        s_d.pin_prev = i_ext_int_pin_n;
        if (!s_q.suspended && s_q.pin_prev && !i_ext_int_pin_n) begin
            s_d.ext_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // remote wake k signalling
        // ------------------------------------------------------------
        pulse_fall = !s_d.rwake_pulse && s_q.rwake_pulse;
        unique case (s_q.k_st)
            usb_susp_pkg::K_OFF: begin
                s_d.k_total = '0;
                if (s_q.rwake_pulse) begin
                    s_d.k_st = usb_susp_pkg::K_PULSE;
                end
            end
            usb_susp_pkg::K_PULSE: begin
                // k follows the pulse for its whole width
                s_d.k_total = s_q.k_total + 1'b1;
                if (pulse_fall || !s_q.rwake_pulse) begin
                    s_d.k_st  = usb_susp_pkg::K_EXT;
                    s_d.k_cnt = '0;
                end
            end
            usb_susp_pkg::K_EXT: begin
                s_d.k_total = s_q.k_total + 1'b1;
                s_d.k_cnt   = s_q.k_cnt + 1'b1;
                if (s_q.k_cnt == KEXT_LIM) begin
                    s_d.k_st = usb_susp_pkg::K_OFF;
                end
            end
        endcase
        // hard stop so an overlong pulse cannot break the bound
        if (s_q.k_st != usb_susp_pkg::K_OFF && s_q.k_total == KMAX_LIM) begin
            s_d.k_st        = usb_susp_pkg::K_OFF;
            s_d.rwake_pulse = 1'b0;
        end
        s_d.k_drive = (s_d.k_st != usb_susp_pkg::K_OFF);

        // ------------------------------------------------------------
        // clocks and interrupts
        // ------------------------------------------------------------
        s_d.clk_run  = !s_d.suspended;
        s_d.int_zero = (s_d.wake || s_d.ext_flag) && s_d.external_interrupt_pin_en;
        s_d.usb_irq  = s_d.susp_req || s_d.res_req;

        // ------------------------------------------------------------
        // reads, flags and idle bit visible to firmware
        // ------------------------------------------------------------
        if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (i_arvalid && s_q.arready) begin
            do_rd      = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rdata  = '0;
            s_d.rresp  = addr_ok(i_araddr) ? usb_susp_pkg::RESP_OKAY
                                           : usb_susp_pkg::RESP_SLVERR;
            unique case (i_araddr)
                usb_susp_pkg::OFS_USB_CTRL: begin
                    s_d.rdata[usb_susp_pkg::BIT_RWAKE_PULSE] = s_q.rwake_pulse;
                    s_d.rdata[usb_susp_pkg::BIT_RWAKE_EN]    = s_q.rwake_en;
                end
                usb_susp_pkg::OFS_GLOB_CTRL: begin
                    s_d.rdata[usb_susp_pkg::BIT_EXTERNAL_INTERRUPT_PIN_EN] = s_q.external_interrupt_pin_en;
                end
                usb_susp_pkg::OFS_PWR_CTRL: begin
                    s_d.rdata[usb_susp_pkg::BIT_IDLE] = s_q.idle_mode;
                end
                usb_susp_pkg::OFS_VECTOR: begin
                    s_d.rdata[7:0] = vec;
                end
                usb_susp_pkg::OFS_WAKE_MASK: begin
                    s_d.rdata[PORT_W-1:0] = s_q.wake_mask;
                end
                usb_susp_pkg::OFS_STATUS: begin
                    s_d.rdata[usb_susp_pkg::ST_SUSP_REQ]  = s_q.susp_req;
                    s_d.rdata[usb_susp_pkg::ST_RES_REQ]   = s_q.res_req;
                    s_d.rdata[usb_susp_pkg::ST_WAKE]      = s_q.wake;
                    s_d.rdata[usb_susp_pkg::ST_SUSPENDED] = s_q.suspended;
                    s_d.rdata[usb_susp_pkg::ST_K_DRIVE]   = s_q.k_drive;
                    s_d.rdata[usb_susp_pkg::ST_CLK_RUN]   = s_q.clk_run;
                end
                default: begin
                    // unmapped reads as zero
                end
            endcase
        end

        // readies registered so every output is a flop
        s_d.awready = !s_d.aw_ok && !s_d.bvalid;
        s_d.wready  = !s_d.w_ok && !s_d.bvalid;
        s_d.arready = !s_d.rvalid && !do_rd;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s_q           <= '0;
            s_q.wake_mask <= usb_susp_pkg::WAKE_MASK_RST;
            s_q.k_st      <= usb_susp_pkg::K_OFF;
            s_q.gate_prev <= 1'b0;
            s_q.pin_prev  <= 1'b1;
            s_q.clk_run   <= 1'b1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------
    assign o_awready   = s_q.awready;
    assign o_wready    = s_q.wready;
    assign o_bvalid    = s_q.bvalid;
    assign o_bresp     = s_q.bresp;
    assign o_arready   = s_q.arready;
    assign o_rvalid    = s_q.rvalid;
    assign o_rdata     = s_q.rdata;
    assign o_rresp     = s_q.rresp;
    assign o_clk_run   = s_q.clk_run;
    assign o_k_drive   = s_q.k_drive;
    assign o_int_zero  = s_q.int_zero;
    assign o_usb_irq   = s_q.usb_irq;
    assign o_suspended = s_q.suspended;
endmodule // usb_suspend_resume_wakeup

//--- tb/usb_susp_monitor.sv
`timescale 1ns/1ps
module usb_susp_monitor #(
    parameter int SUSP_IDLE_CYC = 50,
    parameter int K_EXT_CYC     = 20,
    parameter int K_MAX_CYC     = 200
) (
    // clock and reset
    input wire logic        i_sys_clk, i_sys_rst,
    // bus and handshake inputs
    input wire logic        i_bus_idle, i_bus_active, i_bready, i_rready,
    // watched outputs
    input wire logic        o_bvalid, o_rvalid, o_suspended, o_clk_run, o_k_drive, o_int_zero, o_usb_irq,
    input wire logic [31:0] o_rdata
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    int idle_q; // unbroken idle cycles, saturates so it never wraps
    int k_q;    // cycles of k drive so far
    always_ff @(posedge i_sys_clk) begin
        idle_q <= (i_sys_rst || !i_bus_idle) ? 0 : ((idle_q <= SUSP_IDLE_CYC) ? idle_q + 1 : idle_q);
        k_q    <= (i_sys_rst || !o_k_drive) ? 0 : k_q + 1;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    susp_after_idle_a: assert property ($rose(o_suspended) |-> idle_q >= SUSP_IDLE_CYC)
        else $error("suspend entered before the idle time");
    susp_irq_a: assert property (idle_q == SUSP_IDLE_CYC |-> ##[0:2] o_usb_irq)
        else $error("no suspend request after the idle time");
    bus_resume_a: assert property (o_suspended && i_bus_active |=> !o_suspended && o_clk_run && o_usb_irq)
        else $error("bus activity did not resume the device");
    wake_clk_a: assert property ($rose(o_int_zero) |-> ##[0:1] (o_clk_run && !o_suspended))
        else $error("interrupt zero without running clocks");
    clk_stop_a: assert property ($rose(o_suspended) |-> ##[0:1] !o_clk_run)
        else $error("clocks still running in suspend");
    k_min_a: assert property ($fell(o_k_drive) |-> k_q >= K_EXT_CYC)
        else $error("k state shorter than the extension");
    k_max_a: assert property (k_q <= K_MAX_CYC)
        else $error("k state longer than the cap");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data changed before taken");
    cover property ($rose(o_suspended));
    cover property ($rose(o_int_zero));
    cover property ($fell(o_k_drive));
endmodule // usb_susp_monitor

//--- tb/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic i_sys_clk,
    input  wire logic i_resume,  // bench asks for resume signalling
    input  wire logic i_k_drive, // device k seen on the wire
    output logic      o_bus_idle = 1'b1,
    output logic      o_bus_active = 1'b0
);
    // receiver sees the line a cycle late; k from either end is non-idle
    always @(posedge i_sys_clk) begin
        o_bus_active <= i_resume | i_k_drive;
        o_bus_idle   <= ~(i_resume | i_k_drive);
    end
endmodule // usb_host_model

//--- tb/test_usb_suspend_resume_wakeup.sv
`timescale 1ns/1ps
module test_usb_suspend_resume_wakeup;
    // ------------------------------------------------------------
    // stimulus, dut and host
    // ------------------------------------------------------------
    localparam int SC = 50, KC = 20, KM = 200; // short counts
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, isr = 0, res = 0, pin_n = 1;
    logic [7:0] awa = 0, ara = 0, port = 8'hff;
    logic [31:0] wd = 0, rdv, rdat;
    logic [1:0] rsp, bresp, rresp;
    logic awrdy, wrdy, bvld, arrdy, rvld, crun, kdrv, mcu_interrupt_zero_input, irq, susp, bidle, bact;
    int num_errors = 0, n_tests = 0;
    always #5 clk = ~clk;
    usb_suspend_resume_wakeup #(.SUSP_IDLE_CYC(SC), .K_EXT_CYC(KC), .K_MAX_CYC(KM)) i_dut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_awvalid(awv), .i_awaddr(awa), .o_awready(awrdy),
        .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hf), .o_wready(wrdy), .o_bvalid(bvld), .o_bresp(bresp),
        .i_bready(br), .i_arvalid(arv), .i_araddr(ara), .o_arready(arrdy), .o_rvalid(rvld), .o_rdata(rdat),
        .o_rresp(rresp), .i_rready(rr), .i_bus_idle(bidle), .i_bus_active(bact), .i_port_three(port),
        .i_ext_int_pin_n(pin_n), .i_mcu_in_isr(isr), .o_clk_run(crun), .o_k_drive(kdrv),
        .o_int_zero(mcu_interrupt_zero_input), .o_usb_irq(irq), .o_suspended(susp));
    usb_host_model i_host (.i_sys_clk(clk), .i_resume(res), .i_k_drive(kdrv), .o_bus_idle(bidle),
        .o_bus_active(bact));
    // ------------------------------------------------------------
    // shared tasks; decisions use values seen at the falling edge
    // ------------------------------------------------------------
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task tmo(input int n);
        if (n >= 40) begin
            chk("bus wait", 0, 1);
            final_report();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ha, hw, hb;
        @(posedge clk); awv <= 1; wv <= 1; awa <= a; wd <= d; br <= 1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk); ha = awv & awrdy; hw = wv & wrdy; hb = bvld; rsp = bresp;
            @(posedge clk); if (ha) awv <= 0; if (hw) wv <= 0;
            if (hb) break;
        end
        br <= 0; tmo(n); @(posedge clk); @(negedge clk);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input string s);
        int n;
        logic ha, hb;
        @(posedge clk); arv <= 1; ara <= a; rr <= 1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk); ha = arv & arrdy; hb = rvld; rdv = rdat; rsp = rresp;
            @(posedge clk); if (ha) arv <= 0;
            if (hb) break;
        end
        rr <= 0; tmo(n); @(negedge clk); chk(s, e, rdv);
    endtask
    // wait out the idle time, clear the request, then idle the mcu
    task go_susp;
        repeat (SC + 4) @(posedge clk); @(negedge clk); chk("susp irq", 1, irq);
        rc(usb_susp_pkg::OFS_VECTOR, 32'(usb_susp_pkg::VEC_SUSPEND), "vector");
        wr(usb_susp_pkg::OFS_VECTOR, 0); chk("irq clr", 0, irq);
        wr(usb_susp_pkg::OFS_PWR_CTRL, 1); chk("susp", 1, susp); chk("clk", 0, crun);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rc(usb_susp_pkg::OFS_STATUS, 32'h1 << usb_susp_pkg::ST_CLK_RUN, "status");
        rc(usb_susp_pkg::OFS_WAKE_MASK, 32'(usb_susp_pkg::WAKE_MASK_RST), "mask");
        rc(8'h18, 0, "unmapped"); chk("rresp", usb_susp_pkg::RESP_SLVERR, rsp);
        wr(8'h18, 0); chk("bresp", usb_susp_pkg::RESP_SLVERR, rsp);
        isr <= 1; wr(usb_susp_pkg::OFS_PWR_CTRL, 1); isr <= 0; // handler may not idle
        rc(usb_susp_pkg::OFS_PWR_CTRL, 0, "idle in isr");
    endtask
    task t_resume;
        go_susp();
        @(posedge clk); res <= 1; repeat (3) @(posedge clk); res <= 0; @(negedge clk);
        chk("resumed", 0, susp); chk("clk", 1, crun); chk("irq", 1, irq);
        rc(usb_susp_pkg::OFS_PWR_CTRL, 0, "idle bit");
        rc(usb_susp_pkg::OFS_VECTOR, 32'(usb_susp_pkg::VEC_RESUME), "vector");
        wr(usb_susp_pkg::OFS_VECTOR, 0); chk("res clr", 0, irq);
    endtask
    task t_wake;
        wr(usb_susp_pkg::OFS_WAKE_MASK, 32'h0fe); wr(usb_susp_pkg::OFS_GLOB_CTRL, 1); go_susp();
        @(posedge clk) pin_n <= 0; repeat (3) @(posedge clk); pin_n <= 1;
        @(negedge clk) chk("masked pin", 1, susp);
        @(posedge clk) port <= 8'hfe; repeat (3) @(posedge clk); @(negedge clk);
        chk("mcu_interrupt_zero_input", 1, mcu_interrupt_zero_input); chk("clk", 1, crun);
        rc(usb_susp_pkg::OFS_VECTOR, 32'(usb_susp_pkg::VEC_EXTERNAL_INTERRUPT_PIN), "vector");
        rc(usb_susp_pkg::OFS_PWR_CTRL, 1, "idle bit");
        @(posedge clk) port <= 8'hff; wr(usb_susp_pkg::OFS_PWR_CTRL, 0);
        wr(usb_susp_pkg::OFS_VECTOR, 0); chk("wake clr", 0, mcu_interrupt_zero_input);
    endtask
    task t_rwake;
        int i, n;
        wr(usb_susp_pkg::OFS_USB_CTRL, 1); chk("no grant", 0, kdrv); wr(usb_susp_pkg::OFS_USB_CTRL, 0);
        for (i = 0; i < 2; i++) begin
            wr(usb_susp_pkg::OFS_USB_CTRL, 3); repeat (i * 40) @(posedge clk);
            wr(usb_susp_pkg::OFS_USB_CTRL, 2); chk("k on", 1, kdrv);
            for (n = 0; kdrv && n < KM; n++) @(negedge clk);
            chk("k tail", 1, n >= KC - 8 && n <= KC + 1);
        end
    endtask
    task final_report;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk); rst <= 0; @(posedge clk);
        t_reset(); t_resume(); t_wake(); t_rwake(); final_report();
    end
endmodule // test_usb_suspend_resume_wakeup
bind usb_suspend_resume_wakeup usb_susp_monitor #(.SUSP_IDLE_CYC(SUSP_IDLE_CYC), .K_EXT_CYC(K_EXT_CYC),
    .K_MAX_CYC(K_MAX_CYC)) i_mon (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus_idle(i_bus_idle),
    .i_bus_active(i_bus_active), .i_bready(i_bready), .i_rready(i_rready), .o_bvalid(o_bvalid),
    .o_rvalid(o_rvalid), .o_suspended(o_suspended), .o_clk_run(o_clk_run), .o_k_drive(o_k_drive),
    .o_int_zero(o_int_zero), .o_usb_irq(o_usb_irq), .o_rdata(o_rdata));
